// file: common/tftcd_defines.vh
// Opcodes, register offsets and sizes of the host command decoder
`ifndef TFTCD_DEFINES_VH
`define TFTCD_DEFINES_VH
`define TCD_OP_GET_PWR   8'h0a
`define TCD_OP_SLP_IN    8'h10
`define TCD_OP_SLP_OUT   8'h11
`define TCD_OP_PART      8'h12
`define TCD_OP_NORM      8'h13
`define TCD_OP_INV_OFF   8'h20
`define TCD_OP_INV_ON    8'h21
`define TCD_OP_DISP_OFF  8'h28
`define TCD_OP_DISP_ON   8'h29
`define TCD_OP_COL       8'h2a
`define TCD_OP_PAGE      8'h2b
`define TCD_OP_WR_START  8'h2c
`define TCD_OP_RD_START  8'h2e
`define TCD_OP_TEAR_OFF  8'h34
`define TCD_OP_TEAR_ON   8'h35
`define TCD_OP_IDLE_OFF  8'h38
`define TCD_OP_IDLE_ON   8'h39
`define TCD_OP_WR_CONT   8'h3c
`define TCD_OP_GPIO_CONF 8'hb8
`define TCD_OP_GPIO_VAL  8'hba
`define TCD_OP_GPIO_GET  8'hbb
`define TCD_OP_PLL       8'he0
`define TCD_OP_PLL_MN    8'he2
`define TCD_OP_PLL_GET   8'he3
`define TCD_GRP_GEN      5'h18
`define TCD_GRP_ROP      5'h19
`define TCD_OFS_CTRL     12'h000
`define TCD_OFS_STATUS   12'h004
`define TCD_OFS_PTR      12'h008
`define TCD_CTRL_RST     1'h1
`define TCD_COL_MAX      9'h1df
`define TCD_PAGE_MAX     9'h10f
`define TCD_LINE_PIX     17'h001e0
`define TCD_IDX_MAX      4'hf
`endif

// file: design/tftcd_top.v
// Host port command decoder of the TFT display controller
`timescale 1ns/1ps
`default_nettype none
`include "tftcd_defines.vh"
module tftcd_top (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Host parallel port
  input  wire        hp_cs_n,
  input  wire        hp_wr_n,
  input  wire        hp_rd_n,
  input  wire        data_command_select,
  input  wire [7:0]  hp_data_in,
  output wire [7:0]  hp_data_out,
  output wire        hp_data_oe,
  // Frame sync
  input  wire        vertical_front_porch,
  output wire        frame_sync_out,
  // GPIO lines
  input  wire [3:0]  gpio_in,
  output wire [3:0]  gpio_out,
  output wire [3:0]  gpio_oe,
  output wire        panel_standby_line,
  output wire [3:0]  gen_out,
  // Display mode state
  output wire        panel_on,
  output wire        partial_mode,
  output wire        invert_mode,
  output wire        display_on,
  output wire        idle_mode,
  // PLL control
  output wire        pll_enable,
  output wire        pll_select,
  output wire [7:0]  pll_mult,
  output wire [7:0]  pll_div,
  // Frame memory port
  output wire        mem_we,
  output wire        mem_re,
  output wire [16:0] mem_addr,
  output wire [23:0] mem_wdata,
  input  wire [23:0] mem_rdata
);

  function [16:0] addr_of;
    input [8:0] p;
    input [8:0] c;
    reg   [33:0] m;
    begin
      m = {8'h00, p} * `TCD_LINE_PIX;
      addr_of = m[16:0] + {8'h00, c};
    end
  endfunction

  function rop_eval;
    input [7:0] r;
    input [3:0] g;
    reg         a;
    reg         b;
    begin
      a = g[r[1:0]];
      b = g[r[3:2]];
      case (r[5:4])
        2'h0:    rop_eval = a;
        2'h1:    rop_eval = a & b;
        2'h2:    rop_eval = a | b;
        default: rop_eval = a ^ b;
      endcase
    end
  endfunction

  // Pin synchronisers
  reg [2:0]  wr_sy_ff;
  reg [2:0]  rd_sy_ff;
  reg [1:0]  cs_sy_ff;
  reg [1:0]  dcs_sy_ff;
  reg [7:0]  d_s1_ff;
  reg [7:0]  d_s2_ff;
  reg [3:0]  gi_s1_ff;
  reg [3:0]  gi_s2_ff;
  // Decoder state
  reg        ctrl_en_ff;
  reg [7:0]  byte_ff;
  reg        dc_ff;
  reg [7:0]  cmd_ff;
  reg [3:0]  idx_ff;
  reg [1:0]  ph_ff;
  reg [7:0]  red_ff;
  reg [7:0]  grn_ff;
  reg [8:0]  cs_ff;
  reg [8:0]  ce_ff;
  reg [8:0]  ps_ff;
  reg [8:0]  pe_ff;
  reg [8:0]  col_ff;
  reg [8:0]  page_ff;
  reg        rd_req_ff;
  reg        re_d_ff;
  reg [23:0] pix_rd_ff;
  reg        mem_we_ff;
  reg        mem_re_ff;
  reg [16:0] mem_addr_ff;
  reg [23:0] mem_wdata_ff;
  reg [7:0]  dout_ff;
  reg [31:0] prdata_ff;
  reg        pslverr_ff;
  reg        panel_on_ff;
  reg        part_ff;
  reg        inv_ff;
  reg        disp_ff;
  reg        idle_ff;
  reg        tear_on_ff;
  reg        fsync_ff;
  reg [3:0]  dir_ff;
  reg [3:0]  pnl_ff;
  reg        gp0_gen_ff;
  reg [3:0]  val_ff;
  reg        stby_ff;
  reg [3:0]  gpio_out_ff;
  reg [3:0]  gpio_oe_ff;
  reg [3:0]  gen_out_ff;
  reg        pll_en_ff;
  reg        pll_sel_ff;
  reg [7:0]  pll_m_ff;
  reg [7:0]  pll_n_ff;
  reg [7:0]  gen_ff [0:15];
  reg [7:0]  rop_ff [0:3];
  reg [8:0]  nxt_col;
  reg [8:0]  nxt_page;
  reg [7:0]  nxt_rb;
  reg [3:0]  nxt_gout;
  reg [3:0]  nxt_goe;
  reg [3:0]  gstat;
  wire [3:0] gen_raw;
  wire [3:0] rop_raw;
  integer    i;

  wire host_ok = ~cs_sy_ff[1] & ctrl_en_ff;
  wire wr_rise = wr_sy_ff[1] & ~wr_sy_ff[2] & host_ok;
  wire rd_rise = rd_sy_ff[1] & ~rd_sy_ff[2] & host_ok;
  wire wr_mode = (cmd_ff == `TCD_OP_WR_START) | (cmd_ff == `TCD_OP_WR_CONT);
  wire rd_mode = (cmd_ff == `TCD_OP_RD_START);
  wire gp0_std = ~gp0_gen_ff & ~pnl_ff[0];
  wire [3:0] gen_ok = dir_ff & ~pnl_ff & {~gp0_std, 3'h7};
  wire [3:0] idx_inc = (idx_ff == `TCD_IDX_MAX) ? idx_ff : idx_ff + 4'h1;
  wire apb_wr = psel & penable & pwrite;

  // Signal generators and combination per line
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_u
      reg [7:0] cnt_ff;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_ff <= 8'h00;
        end else if (!gen_ff[4*g+3][0] || cnt_ff >= gen_ff[4*g+2]) begin
          cnt_ff <= 8'h00;
        end else begin
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
      assign gen_raw[g] = gen_ff[4*g+3][0] & (cnt_ff >= gen_ff[4*g]) &
                          (cnt_ff < gen_ff[4*g+1]);
      assign rop_raw[g] = rop_eval(rop_ff[g], gen_raw);
    end
  endgenerate

  // Window walk and GPIO drive
  always @* begin
    nxt_col  = col_ff + 9'h001;
    nxt_page = page_ff;
    if (col_ff >= ce_ff) begin
      nxt_col  = cs_ff;
      nxt_page = (page_ff >= pe_ff) ? ps_ff : page_ff + 9'h001;
    end
    nxt_goe  = dir_ff | pnl_ff;
    nxt_gout = (pnl_ff & rop_raw) | (~pnl_ff & val_ff);
    if (gp0_std) begin
      nxt_goe[0]  = 1'b1;
      nxt_gout[0] = stby_ff;
    end
    gstat = (dir_ff & val_ff) | (~dir_ff & gi_s2_ff);
    if (pnl_ff[0] | gp0_std) begin
      gstat[0] = nxt_gout[0];
    end
  end

  // Read-back byte for the current command and index
  always @* begin
    nxt_rb = 8'h00;
    case (cmd_ff)
      `TCD_OP_GET_PWR: nxt_rb = {3'h0, idle_ff, disp_ff, inv_ff, part_ff,
                                 panel_on_ff};
      `TCD_OP_GPIO_GET: nxt_rb = {4'h0, gstat};
      `TCD_OP_PLL_GET: nxt_rb = (idx_ff == 4'h0) ? pll_m_ff :
                                (idx_ff == 4'h1) ? pll_n_ff : 8'h00;
      default: begin
        if (cmd_ff[7:3] == `TCD_GRP_GEN && cmd_ff[0]) begin
          nxt_rb = (idx_ff < 4'h4) ? gen_ff[{cmd_ff[2:1], idx_ff[1:0]}]
                                   : 8'h00;
        end else if (cmd_ff[7:3] == `TCD_GRP_ROP && cmd_ff[0]) begin
          nxt_rb = (idx_ff == 4'h0) ? rop_ff[cmd_ff[2:1]] : 8'h00;
        end
      end
    endcase
  end

  // Synchronisers, APB slave
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_sy_ff   <= 3'h7;
      rd_sy_ff   <= 3'h7;
      cs_sy_ff   <= 2'h3;
      dcs_sy_ff  <= 2'h3;
      d_s1_ff    <= 8'h00;
      d_s2_ff    <= 8'h00;
      gi_s1_ff   <= 4'h0;
      gi_s2_ff   <= 4'h0;
      ctrl_en_ff <= `TCD_CTRL_RST;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      wr_sy_ff  <= {wr_sy_ff[1:0], hp_wr_n};
      rd_sy_ff  <= {rd_sy_ff[1:0], hp_rd_n};
      cs_sy_ff  <= {cs_sy_ff[0], hp_cs_n};
      dcs_sy_ff <= {dcs_sy_ff[0], data_command_select};
      d_s1_ff   <= hp_data_in;
      d_s2_ff   <= d_s1_ff;
      gi_s1_ff  <= gpio_in;
      gi_s2_ff  <= gi_s1_ff;
      if (apb_wr && paddr == `TCD_OFS_CTRL) begin
        ctrl_en_ff <= pwdata[0];
      end
      if (psel && !penable) begin
        pslverr_ff <= 1'b0;
        case (paddr)
          `TCD_OFS_CTRL:   prdata_ff <= {31'h0, ctrl_en_ff};
          `TCD_OFS_STATUS: prdata_ff <= {24'h0, pll_sel_ff, pll_en_ff,
                                         tear_on_ff, idle_ff, disp_ff,
                                         inv_ff, part_ff, panel_on_ff};
          `TCD_OFS_PTR:    prdata_ff <= {7'h0, page_ff, 7'h0, col_ff};
          default: begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b1;
          end
        endcase
      end
    end
  end

  // Command decoder
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_ff <= 8'h00;
      dc_ff <= 1'b0;
      cmd_ff <= 8'h00;
      idx_ff <= 4'h0;
      ph_ff <= 2'h0;
      red_ff <= 8'h00;
      grn_ff <= 8'h00;
      cs_ff <= 9'h000;
      ce_ff <= `TCD_COL_MAX;
      ps_ff <= 9'h000;
      pe_ff <= `TCD_PAGE_MAX;
      col_ff <= 9'h000;
      page_ff <= 9'h000;
      rd_req_ff <= 1'b0;
      re_d_ff <= 1'b0;
      pix_rd_ff <= 24'h000000;
      mem_we_ff <= 1'b0;
      mem_re_ff <= 1'b0;
      mem_addr_ff <= 17'h00000;
      mem_wdata_ff <= 24'h000000;
      dout_ff <= 8'h00;
      panel_on_ff <= 1'b0;
      part_ff <= 1'b0;
      inv_ff <= 1'b0;
      disp_ff <= 1'b0;
      idle_ff <= 1'b0;
      tear_on_ff <= 1'b0;
      fsync_ff <= 1'b0;
      dir_ff <= 4'h0;
      pnl_ff <= 4'h0;
      gp0_gen_ff <= 1'b0;
      val_ff <= 4'h0;
      stby_ff <= 1'b0;
      gpio_out_ff <= 4'h0;
      gpio_oe_ff <= 4'h0;
      gen_out_ff <= 4'h0;
      pll_en_ff <= 1'b0;
      pll_sel_ff <= 1'b0;
      pll_m_ff <= 8'h00;
      pll_n_ff <= 8'h00;
      for (i = 0; i < 16; i = i + 1) begin
        gen_ff[i] <= 8'h00;
      end
      for (i = 0; i < 4; i = i + 1) begin
        rop_ff[i] <= 8'h00;
      end
    end else begin
      mem_we_ff <= 1'b0;
      mem_re_ff <= 1'b0;
      re_d_ff <= mem_re_ff;
      fsync_ff <= tear_on_ff & vertical_front_porch;
      gpio_out_ff <= nxt_gout;
      gpio_oe_ff <= nxt_goe;
      gen_out_ff <= gen_raw;
      dout_ff <= rd_mode ? ((ph_ff == 2'h0) ? pix_rd_ff[23:16] :
                            (ph_ff == 2'h1) ? pix_rd_ff[15:8] :
                            pix_rd_ff[7:0]) : nxt_rb;
      if (!wr_sy_ff[1]) begin
        byte_ff <= d_s2_ff;
        dc_ff <= dcs_sy_ff[1];
      end
      if (re_d_ff) begin
        pix_rd_ff <= mem_rdata;
      end
      if (rd_req_ff) begin
        rd_req_ff <= 1'b0;
        mem_re_ff <= 1'b1;
        mem_addr_ff <= addr_of(page_ff, col_ff);
        col_ff <= nxt_col;
        page_ff <= nxt_page;
      end
      if (wr_rise && !dc_ff) begin
        cmd_ff <= byte_ff;
        idx_ff <= 4'h0;
        ph_ff <= 2'h0;
        rd_req_ff <= 1'b0;
        case (byte_ff)
          `TCD_OP_SLP_IN: begin
            if (gp0_std) begin
              panel_on_ff <= 1'b0;
              stby_ff <= 1'b0;
            end
          end
          `TCD_OP_SLP_OUT: begin
            if (gp0_std) begin
              panel_on_ff <= 1'b1;
              stby_ff <= 1'b1;
            end
          end
          `TCD_OP_PART:     part_ff <= 1'b1;
          `TCD_OP_NORM:     part_ff <= 1'b0;
          `TCD_OP_INV_OFF:  inv_ff <= 1'b0;
          `TCD_OP_INV_ON:   inv_ff <= 1'b1;
          `TCD_OP_DISP_OFF: disp_ff <= 1'b0;
          `TCD_OP_DISP_ON:  disp_ff <= 1'b1;
          `TCD_OP_TEAR_OFF: tear_on_ff <= 1'b0;
          `TCD_OP_TEAR_ON:  tear_on_ff <= 1'b1;
          `TCD_OP_IDLE_OFF: idle_ff <= 1'b0;
          `TCD_OP_IDLE_ON:  idle_ff <= 1'b1;
          `TCD_OP_WR_START, `TCD_OP_RD_START: begin
            col_ff <= cs_ff;
            page_ff <= ps_ff;
            rd_req_ff <= (byte_ff == `TCD_OP_RD_START);
          end
          default: begin
          end
        endcase
      end else if (wr_rise && wr_mode) begin
        ph_ff <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
        if (ph_ff == 2'h0) begin
          red_ff <= byte_ff;
        end else if (ph_ff == 2'h1) begin
          grn_ff <= byte_ff;
        end else begin
          mem_we_ff <= 1'b1;
          mem_wdata_ff <= {red_ff, grn_ff, byte_ff};
          mem_addr_ff <= addr_of(page_ff, col_ff);
          col_ff <= nxt_col;
          page_ff <= nxt_page;
        end
      end else if (wr_rise) begin
        idx_ff <= idx_inc;
        case (cmd_ff)
          `TCD_OP_COL, `TCD_OP_PAGE: begin
            case (idx_ff)
              4'h0: if (cmd_ff[0]) ps_ff[8] <= byte_ff[0];
                    else cs_ff[8] <= byte_ff[0];
              4'h1: if (cmd_ff[0]) ps_ff[7:0] <= byte_ff;
                    else cs_ff[7:0] <= byte_ff;
              4'h2: if (cmd_ff[0]) pe_ff[8] <= byte_ff[0];
                    else ce_ff[8] <= byte_ff[0];
              4'h3: if (cmd_ff[0]) pe_ff[7:0] <= byte_ff;
                    else ce_ff[7:0] <= byte_ff;
              default: begin
              end
            endcase
          end
          `TCD_OP_GPIO_CONF: begin
            if (idx_ff == 4'h0) begin
              pnl_ff <= byte_ff[7:4];
              dir_ff <= byte_ff[3:0];
            end else if (idx_ff == 4'h1) begin
              gp0_gen_ff <= byte_ff[0];
            end
          end
          `TCD_OP_GPIO_VAL: begin
            if (idx_ff == 4'h0) begin
              val_ff <= (val_ff & ~gen_ok) | (byte_ff[3:0] & gen_ok);
            end
          end
          `TCD_OP_PLL: begin
            if (idx_ff == 4'h0) begin
              pll_en_ff <= byte_ff[0];
              pll_sel_ff <= byte_ff[1] & byte_ff[0];
            end
          end
          `TCD_OP_PLL_MN: begin
            if (idx_ff == 4'h0) pll_m_ff <= byte_ff;
            if (idx_ff == 4'h1) pll_n_ff <= byte_ff;
          end
          default: begin
            if (cmd_ff[7:3] == `TCD_GRP_GEN && !cmd_ff[0] && idx_ff < 4'h4) begin
              gen_ff[{cmd_ff[2:1], idx_ff[1:0]}] <= byte_ff;
            end else if (cmd_ff[7:3] == `TCD_GRP_ROP && !cmd_ff[0] &&
                         idx_ff == 4'h0) begin
              rop_ff[cmd_ff[2:1]] <= byte_ff;
            end
          end
        endcase
      end
      if (rd_rise && rd_mode) begin
        ph_ff <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
        rd_req_ff <= (ph_ff == 2'h2);
      end else if (rd_rise) begin
        idx_ff <= idx_inc;
      end
    end
  end

  assign prdata             = prdata_ff;
  assign pready             = 1'b1;
  assign pslverr            = pslverr_ff & psel & penable;
  assign hp_data_out        = dout_ff;
  assign hp_data_oe         = host_ok & ~rd_sy_ff[1];
  assign frame_sync_out     = fsync_ff;
  assign gpio_out           = gpio_out_ff;
  assign gpio_oe            = gpio_oe_ff;
  assign panel_standby_line = gpio_out_ff[0];
  assign gen_out            = gen_out_ff;
  assign panel_on           = panel_on_ff;
  assign partial_mode       = part_ff;
  assign invert_mode        = inv_ff;
  assign display_on         = disp_ff;
  assign idle_mode          = idle_ff;
  assign pll_enable         = pll_en_ff;
  assign pll_select         = pll_sel_ff;
  assign pll_mult           = pll_m_ff;
  assign pll_div            = pll_n_ff;
  assign mem_we             = mem_we_ff;
  assign mem_re             = mem_re_ff;
  assign mem_addr           = mem_addr_ff;
  assign mem_wdata          = mem_wdata_ff;

endmodule
`default_nettype wire

// file: tb/tftcd_host.sv
// Host processor model on the parallel command port
`timescale 1ns/1ps
`default_nettype none
module tftcd_host (
  // Clock
  input  wire logic       pclk,
  // Strobes and data towards the decoder
  output var  logic       cs_n,
  output var  logic       wr_n,
  output var  logic       rd_n,
  output var  logic       dc_sel,
  output var  logic [7:0] dout,
  // Read data
  input  wire logic [7:0] din
);
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    dc_sel = 1'b1;
    dout = 8'ha5;
  end
  // One byte, strobes held past the sync delay
  task automatic put(input logic dc, input logic [7:0] b);
    @(posedge pclk);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    dc_sel <= dc;
    dout <= b;
    repeat (4) @(posedge pclk);
    wr_n <= 1'b1;
    repeat (5) @(posedge pclk);
    cs_n <= 1'b1;
    dout <= ~b;
  endtask
  // Command code, then n parameters, high byte first
  task automatic send(input logic [7:0] op, input logic [31:0] p,
                      input int n);
    put(1'b0, op);
    for (int i = n - 1; i >= 0; i--) put(1'b1, p[8*i +: 8]);
  endtask
  // Pixel as red, green, blue
  task automatic pix(input logic [23:0] c);
    for (int i = 2; i >= 0; i--) put(1'b1, c[8*i +: 8]);
  endtask
  // One read strobe
  task automatic get(output logic [7:0] b);
    @(posedge pclk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (6) @(posedge pclk);
    b = din;
    rd_n <= 1'b1;
    repeat (5) @(posedge pclk);
    cs_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: tb/tftcd_props.sv
// Concurrent checks on the host command decoder ports
`timescale 1ns/1ps
`default_nettype none
module tftcd_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // Host port
  input wire logic        hp_cs_n,
  input wire logic        hp_rd_n,
  input wire logic        hp_data_oe,
  // Sync, GPIO and modes
  input wire logic        vertical_front_porch,
  input wire logic        frame_sync_out,
  input wire logic        panel_on,
  input wire logic        panel_standby_line,
  input wire logic        invert_mode,
  input wire logic        pll_enable,
  input wire logic        pll_select,
  // Frame memory
  input wire logic        mem_we,
  input wire logic        mem_re,
  input wire logic [16:0] mem_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_high: assert property (pready)
    else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_sync_cause: assert property (
    frame_sync_out |-> $past(vertical_front_porch))
    else $error("frame sync without front porch");
  a_standby_line: assert property (
    $changed(panel_on) |=> panel_standby_line == panel_on)
    else $error("standby does not follow panel power");
  a_we_single: assert property (mem_we |=> !mem_we)
    else $error("memory write longer than one cycle");
  a_mem_excl: assert property (!(mem_we && mem_re))
    else $error("memory read and write together");
  a_addr_range: assert property (
    mem_we || mem_re |-> mem_addr < 17'h1fe00)
    else $error("memory address beyond panel");
  a_oe_after_rd: assert property ($rose(hp_data_oe) |->
    $past(hp_rd_n, 2) == 1'b0 && $past(hp_cs_n, 2) == 1'b0)
    else $error("data drive without read strobe");
  a_pll_order: assert property (pll_select |-> pll_enable)
    else $error("pll selected while off");
  a_inv_cause: assert property (
    $changed(invert_mode) |-> $past(hp_cs_n, 3) == 1'b0)
    else $error("invert changed without host access");
endmodule
bind tftcd_top tftcd_props u_props (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .hp_cs_n, .hp_rd_n, .hp_data_oe,
  .vertical_front_porch, .frame_sync_out, .panel_on, .panel_standby_line,
  .invert_mode, .pll_enable, .pll_select, .mem_we, .mem_re, .mem_addr);
`default_nettype wire

// file: tb/tftcd_top_bench.sv
// Self-checking bench of the host command decoder
`timescale 1ns/1ps
`default_nettype none
`include "tftcd_defines.vh"
module tftcd_top_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        hp_cs_n, hp_wr_n, hp_rd_n, data_command_select, hp_data_oe;
  logic [7:0]  hp_data_in, hp_data_out, pll_mult, pll_div;
  logic        vertical_front_porch, frame_sync_out, panel_standby_line;
  logic [3:0]  gpio_in, gpio_out, gpio_oe, gen_out;
  logic        panel_on, partial_mode, invert_mode, display_on, idle_mode;
  logic        pll_enable, pll_select, mem_we, mem_re;
  logic [16:0] mem_addr;
  logic [23:0] mem_wdata, mem_rdata;
  logic [23:0] fmem [0:131071];
  logic [40:0] wq [$];
  int          err_count, comparisons, cycles;

  tftcd_top uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .hp_cs_n, .hp_wr_n, .hp_rd_n,
    .data_command_select, .hp_data_in, .hp_data_out, .hp_data_oe,
    .vertical_front_porch, .frame_sync_out, .gpio_in, .gpio_out, .gpio_oe,
    .panel_standby_line, .gen_out, .panel_on, .partial_mode, .invert_mode,
    .display_on, .idle_mode, .pll_enable, .pll_select, .pll_mult, .pll_div,
    .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata);
  tftcd_host host (.pclk, .cs_n(hp_cs_n), .wr_n(hp_wr_n), .rd_n(hp_rd_n),
    .dc_sel(data_command_select), .dout(hp_data_in), .din(hp_data_out));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Frame memory, one cycle read
  always @(posedge pclk) begin
    if (mem_we) begin
      fmem[mem_addr] <= mem_wdata;
      wq.push_back({mem_addr, mem_wdata});
    end
    if (mem_re) mem_rdata <= fmem[mem_addr];
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    if (a == 12'h0f0) check("unmapped err", 32'(pslverr), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cnt_hi(input int s, output int n);
    n = 0;
    repeat (12) begin
      @(negedge pclk);
      n += s ? gpio_out[0] : gen_out[0];
    end
  endtask

  task automatic t_apb;
    logic [31:0] q;
    apb(1'b0, `TCD_OFS_CTRL, 32'h0, q);
    check("ctrl reset", q, 32'h1);
    apb(1'b0, `TCD_OFS_STATUS, 32'h0, q);
    check("status reset", q, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0, q);
    check("unmapped data", q, 32'h0);
    apb(1'b1, `TCD_OFS_CTRL, 32'h0, q);
    host.send(`TCD_OP_INV_ON, 32'h0, 0);
    check("port off", 32'(invert_mode), 32'h0);
    apb(1'b1, `TCD_OFS_CTRL, 32'h1, q);
    $display("test apb done");
  endtask
  task automatic t_modes;
    logic [7:0] ops [10];
    int bitn [10];
    logic [7:0] ex, b;
    logic [31:0] q;
    ops = '{`TCD_OP_INV_ON, `TCD_OP_PART, `TCD_OP_DISP_ON, `TCD_OP_IDLE_ON,
      `TCD_OP_TEAR_ON, `TCD_OP_INV_OFF, `TCD_OP_NORM, `TCD_OP_DISP_OFF,
      `TCD_OP_IDLE_OFF, `TCD_OP_TEAR_OFF};
    bitn = '{2, 1, 3, 4, 5, 2, 1, 3, 4, 5};
    ex = 8'h00;
    for (int i = 0; i < 10; i++) begin
      host.send(ops[i], 32'h0, 0);
      ex[bitn[i]] = (i < 5);
      apb(1'b0, `TCD_OFS_STATUS, 32'h0, q);
      check("status", q, 32'(ex));
      check("mode pins", 32'({idle_mode, display_on, invert_mode,
        partial_mode, panel_on}), 32'(ex[4:0]));
      if (i == 4) begin
        host.send(`TCD_OP_GET_PWR, 32'h0, 0);
        host.get(b);
        check("power mode", 32'(b[4:0]), 32'(ex[4:0]));
      end
    end
    $display("test modes done");
  endtask
  task automatic t_tear;
    for (int t = 0; t < 2; t++) begin
      host.send(t ? `TCD_OP_TEAR_OFF : `TCD_OP_TEAR_ON, 32'h0, 0);
      @(posedge pclk);
      vertical_front_porch <= 1'b1;
      @(posedge pclk);
      vertical_front_porch <= 1'b0;
      @(negedge pclk);
      check("frame sync", 32'(frame_sync_out), 32'(t == 0));
    end
    $display("test tear done");
  endtask
  task automatic t_gpio;
    logic [7:0] b;
    host.send(`TCD_OP_SLP_OUT, 32'h0, 0);
    check("wake", 32'({panel_on, panel_standby_line}), 32'h3);
    host.send(`TCD_OP_SLP_IN, 32'h0, 0);
    check("sleep", 32'({panel_on, panel_standby_line}), 32'h0);
    host.send(`TCD_OP_GPIO_CONF, 32'h0f01, 2);
    host.send(`TCD_OP_SLP_OUT, 32'h0, 0);
    check("wake ignored", 32'(panel_on), 32'h0);
    host.send(`TCD_OP_GPIO_VAL, 32'h05, 1);
    check("gpio out", 32'({gpio_oe, gpio_out}), 32'hf5);
    host.send(`TCD_OP_GPIO_CONF, 32'h0e01, 2);
    host.send(`TCD_OP_GPIO_VAL, 32'h0a, 1);
    check("gpio in", 32'({gpio_oe, gpio_out[3:1]}), 32'h75);
    host.send(`TCD_OP_GPIO_GET, 32'h0, 0);
    host.get(b);
    check("gpio status", 32'(b[3:0]), 32'ha);
    $display("test gpio done");
  endtask
  task automatic t_pix;
    logic [16:0] ea [4];
    logic [23:0] c;
    logic [7:0] b;
    ea = '{17'h0096a, 17'h0096b, 17'h00b4a, 17'h00b4b};
    host.send(`TCD_OP_COL, 32'h000a000b, 4);
    host.send(`TCD_OP_PAGE, 32'h00050006, 4);
    wq.delete();
    host.send(`TCD_OP_WR_START, 32'h0, 0);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) host.send(`TCD_OP_WR_CONT, 32'h0, 0);
      host.pix(24'h102030 + 24'(i) * 24'h010101);
    end
    check("pixel count", wq.size(), 32'h4);
    for (int i = 0; i < 4; i++) begin
      check("pixel addr", 32'(wq[i][40:24]), 32'(ea[i]));
      c = 24'h102030 + 24'(i) * 24'h010101;
      check("pixel data", 32'(wq[i][23:0]), 32'(c));
    end
    c = 24'h102030;
    host.send(`TCD_OP_RD_START, 32'h0, 0);
    for (int i = 2; i >= 0; i--) begin
      host.get(b);
      check("pixel read", 32'(b), 32'(c[8*i +: 8]));
    end
    $display("test pixels done");
  endtask
  task automatic t_nop;
    logic [31:0] s0, s1, p0, p1;
    apb(1'b0, `TCD_OFS_STATUS, 32'h0, s0);
    apb(1'b0, `TCD_OFS_PTR, 32'h0, p0);
    wq.delete();
    host.send(8'h00, 32'h2c, 1);
    host.send(8'h0c, 32'h2129ff, 3);
    apb(1'b0, `TCD_OFS_STATUS, 32'h0, s1);
    apb(1'b0, `TCD_OFS_PTR, 32'h0, p1);
    check("nop status", s1, s0);
    check("nop pointer", p1, p0);
    check("nop writes", wq.size(), 32'h0);
    $display("test nop done");
  endtask
  task automatic t_pll;
    logic [7:0] b;
    host.send(`TCD_OP_PLL_MN, 32'h3b02, 2);
    check("pll mn", 32'({pll_mult, pll_div}), 32'h3b02);
    host.send(`TCD_OP_PLL_GET, 32'h0, 0);
    host.get(b);
    check("pll mult back", 32'(b), 32'h3b);
    host.get(b);
    check("pll div back", 32'(b), 32'h02);
    for (int p = 0; p < 4; p++) begin
      host.send(`TCD_OP_PLL, 32'(p), 1);
      check("pll ctl", 32'({pll_select, pll_enable}),
        (p == 3) ? 32'h3 : 32'(p & 1));
    end
    $display("test pll done");
  endtask
  task automatic t_gen;
    logic [31:0] g;
    logic [7:0] b;
    int n;
    g = 32'h01030501;
    host.send(8'hc0, g, 4);
    cnt_hi(0, n);
    check("gen high", n, 32'h4);
    host.send(8'hc1, 32'h0, 0);
    for (int i = 3; i >= 0; i--) begin
      host.get(b);
      check("gen back", 32'(b), 32'(g[8*i +: 8]));
    end
    host.send(`TCD_OP_GPIO_CONF, 32'h1e00, 2);
    host.send(8'hc8, 32'h00, 1);
    cnt_hi(1, n);
    check("rop line", n, 32'h4);
    host.send(`TCD_OP_GPIO_CONF, 32'h0f01, 2);
    host.send(8'hc8, 32'h00, 1);
    cnt_hi(1, n);
    check("rop ignored", n, 32'hc);
    $display("test generators done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    vertical_front_porch = 1'b0;
    gpio_in = 4'h4;
    mem_rdata = 24'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_apb();
    t_modes();
    t_tear();
    t_gpio();
    t_pix();
    t_nop();
    t_pll();
    t_gen();
    tally_and_finish();
  end
endmodule
`default_nettype wire
